// *** core/pin_filter.sv ***
`timescale 1ns/10ps
module pin_filter #(
   parameter int unsigned W = 1,      // Number of pins
   parameter logic [W-1:0] RST_VAL = '0 // Idle level of the pins
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out
);

   // Refuse an empty pin group
   if (W < 1) begin : g_chk
      $error("pin_filter needs at least one pin");
   end

   // Three stages plus the accepted level
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } st_s;

   st_s s_q;
   st_s s_d;

   // First stage is read only by the second one
   always_comb begin
      s_d = s_q;
      s_d.s1 = pin_in;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      // A bit moves only once stages two and three agree
      s_d.q = (~(s_q.s2 ^ s_q.s3) & s_q.s3) | ((s_q.s2 ^ s_q.s3) & s_q.q);
   end

   // Idle level at reset keeps strobes inactive
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   assign pin_out = s_q.q;

endmodule : pin_filter

// *** core/usb_regs_pkg.sv ***
package usb_regs_pkg;

   // Register offsets, reached through the address pointer
   localparam logic [7:0] OFF_CTRL1 = 8'h05;
   localparam logic [7:0] OFF_INT_EN = 8'h06;
   localparam logic [7:0] OFF_INT_FLAGS = 8'h0d;
   localparam logic [7:0] OFF_SET_SEL = 8'h0e;
   localparam logic [7:0] OFF_ROLE = 8'h0f;
   localparam logic [7:0] OFF_FRAME_LO = 8'h15;
   localparam logic [7:0] OFF_FRAME_HI = 8'h16;
   localparam logic [7:0] OFF_CNT_LO = 8'h35;
   localparam logic [7:0] OFF_CNT_HI = 8'h36;

   // Field positions in the flags register
   localparam int FLAG_DMA_BUSY = 7;
   localparam int FLAG_USB_RST = 6;
   localparam int FLAG_SOF = 5;
   localparam int FLAG_DMA_DONE = 4;
   localparam int EVENT_BITS = 7;

   // Field positions in the first control register
   localparam int CTRL1_DMA_EN = 1;
   localparam int CTRL1_DMA_DIR = 2;

   // Field positions in the role and polarity register
   localparam int ROLE_HOST = 7;
   localparam int ROLE_SWAP = 6;

   // Frame number layout in the two frame registers
   localparam int FRAME_W = 11;
   localparam int FRAME_LO_POS = 1;
   localparam int FRAME_HI_POS = 4;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [11:0] RST_PINS = 12'he00;

   // Microprocessor pins after the synchroniser, active low strobes
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic a0;
      logic [7:0] data;
   } cpu_pins_s;

   // Events and state from the serial engine, same clock
   typedef struct packed {
      logic usb_reset;
      logic sof;
      logic [FRAME_W-1:0] frame;
      logic [3:0] ep_done;
      logic [3:0] set_sel;
      logic dma_byte;
   } sie_events_s;

   // Control levels handed to the rest of the controller
   typedef struct packed {
      logic host_mode;
      logic polarity_swap;
      logic dma_active;
      logic dma_dir;
      logic dma_start;
      logic endpoint_three_enable;
   } ctrl_out_s;

endpackage : usb_regs_pkg

// *** core/usb_status_regs.sv ***
`timescale 1ns/10ps
module usb_status_regs import usb_regs_pkg::*; #(
   parameter int unsigned COUNT_W = 16 // DMA byte count width
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire cpu_pins_s cpu_pins,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire sie_events_s sie_ev,
   output ctrl_out_s ctrl,
   output logic [COUNT_W-1:0] dma_remaining,
   output logic interrupt_request_out
);

   // Two byte registers carry the count, so only sixteen fits
   if (COUNT_W != 16) begin : g_chk
      $error("usb_status_regs supports a sixteen bit count only");
   end

   // Whole state of the block
   typedef struct packed {
      logic [7:0] addr;                 // Address pointer
      logic [7:0] ctrl1;                // DMA enable and direction
      logic [7:0] int_en;               // Interrupt mask
      logic [EVENT_BITS-1:0] flags;     // Sticky event flags
      logic [3:0] set_sel;              // Buffer set mirror
      logic [7:0] role;                 // Role and polarity
      logic [FRAME_W-1:0] frame;        // Last frame number
      logic [COUNT_W-1:0] count;        // Programmed byte count
      logic [COUNT_W-1:0] remaining;    // Bytes left in the run
      logic busy;                       // DMA run in progress
      logic start;                      // One-cycle start pulse
      logic wr_prev;                    // Write strobe of last cycle
      logic irq;                        // Registered request
      logic [7:0] rdata;                // Read data latch
      logic oe;                         // Data bus drive
   } st_s;

   st_s s_q;
   st_s s_d;
   cpu_pins_s pins;
   logic rd_act;
   logic wr_act;
   logic wr_pulse;
   logic reg_wr;
   logic hi_wr;
   logic [EVENT_BITS-1:0] clr;
   logic [EVENT_BITS-1:0] setv;
   logic dma_done;
   logic [7:0] rmux;

   // Every pin passes the three stage filter
   pin_filter #(
      .W(12),
      .RST_VAL(RST_PINS)
   ) u_pins (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pin_in(cpu_pins),
      .pin_out(pins)
   );

   // Strobes qualified by chip select
   assign rd_act = !pins.cs_n && !pins.rd_n;
   assign wr_act = !pins.cs_n && !pins.wr_n;
   // A write acts once, on the first filtered cycle
   assign wr_pulse = wr_act && !s_q.wr_prev;
   // A0 high reaches the register at the pointer
   assign reg_wr = wr_pulse && pins.a0;
   assign hi_wr = reg_wr && (s_q.addr == OFF_CNT_HI);

   // Read multiplexer over the pointer
   always_comb begin
      unique case (s_q.addr)
         OFF_CTRL1: rmux = s_q.ctrl1;
         OFF_INT_EN: rmux = s_q.int_en;
         OFF_INT_FLAGS: rmux = {s_q.busy, s_q.flags};
         OFF_SET_SEL: rmux = {4'h0, s_q.set_sel};
         OFF_ROLE: rmux = s_q.role;
         // Undefined frame bits read as zero
         OFF_FRAME_LO: rmux = {s_q.frame[6:0], 1'b0};
         OFF_FRAME_HI: rmux = {s_q.frame[10:7], 4'h0};
         OFF_CNT_LO: rmux = s_q.count[7:0];
         OFF_CNT_HI: rmux = s_q.count[15:8];
         // Unmapped offsets read as zero
         default: rmux = RST_BYTE;
      endcase
   end

   // Next state of the whole block
   always_comb begin
      s_d = s_q;
      clr = '0;
      dma_done = 1'b0;
      s_d.start = 1'b0;
      s_d.wr_prev = wr_act;
      // Buffer set follows the engine
      s_d.set_sel = sie_ev.set_sel;
      // Frame captured at each start of frame
      if (sie_ev.sof) begin
         s_d.frame = sie_ev.frame;
      end
      // A0 low loads the pointer
      if (wr_pulse && !pins.a0) begin
         s_d.addr = pins.data;
      end
      // Register writes
      if (reg_wr) begin
         unique case (s_q.addr)
            OFF_CTRL1: s_d.ctrl1 = pins.data;
            OFF_INT_EN: s_d.int_en = pins.data;
            OFF_INT_FLAGS: clr = pins.data[EVENT_BITS-1:0];
            // Reserved bits are held at zero
            OFF_ROLE: s_d.role = {pins.data[ROLE_HOST], pins.data[ROLE_SWAP], 6'h00};
            OFF_CNT_LO: s_d.count[7:0] = pins.data;
            OFF_CNT_HI: s_d.count[15:8] = pins.data;
            // Frame registers, the buffer set register and unmapped offsets ignore writes
            default: ;
         endcase
      end
      // DMA run: enable must already be set before the high byte
      if (hi_wr && s_q.ctrl1[CTRL1_DMA_EN]) begin
         if ({pins.data, s_q.count[7:0]} == '0) begin
            // Nothing to move, so the run ends at once
            dma_done = 1'b1;
            s_d.busy = 1'b0;
         end else begin
            s_d.busy = 1'b1;
            s_d.start = 1'b1;
            s_d.remaining = {pins.data, s_q.count[7:0]};
         end
      end else if (s_q.busy && sie_ev.dma_byte) begin
         // One byte moved by the engine
         s_d.remaining = s_q.remaining - COUNT_W'(1);
         if (s_q.remaining == COUNT_W'(1)) begin
            s_d.busy = 1'b0;
            dma_done = 1'b1;
         end
      end
      // New events win over a clear in the same cycle
      setv = {sie_ev.usb_reset, sie_ev.sof, dma_done, sie_ev.ep_done};
      s_d.flags = (s_q.flags & ~clr) | setv;
      // Mask only gates the request line
      s_d.irq = |(s_d.flags & s_d.int_en[EVENT_BITS-1:0]);
      // Read data held fresh while the read strobe stands
      s_d.oe = rd_act;
      s_d.rdata = rd_act ? rmux : s_q.rdata;
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs, all from flip-flops
   assign data_out = s_q.rdata;
   assign data_oe = s_q.oe;
   assign interrupt_request_out = s_q.irq;
   assign dma_remaining = s_q.remaining;
   assign ctrl.host_mode = s_q.role[ROLE_HOST];
   assign ctrl.polarity_swap = s_q.role[ROLE_SWAP];
   assign ctrl.dma_active = s_q.busy;
   assign ctrl.dma_dir = s_q.ctrl1[CTRL1_DMA_DIR];
   assign ctrl.dma_start = s_q.start;
   // The third endpoint has no processor path; DMA carries it
   assign ctrl.endpoint_three_enable = s_q.busy;

   // Checks on the behaviour above
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   // Write of the flags register with a given pattern
   sequence s_flag_wr;
      reg_wr && (s_q.addr == OFF_INT_FLAGS);
   endsequence

   // Armed start of a run with a nonzero count
   sequence s_arm;
      hi_wr && s_q.ctrl1[CTRL1_DMA_EN] && ({pins.data, s_q.count[7:0]} != '0);
   endsequence

   // Last byte of a run
   sequence s_last_byte;
      s_q.busy && sie_ev.dma_byte && (s_q.remaining == COUNT_W'(1)) && !hi_wr;
   endsequence

   // Byte that leaves the run going
   sequence s_mid_byte;
      s_q.busy && sie_ev.dma_byte && (s_q.remaining != COUNT_W'(1)) && !hi_wr;
   endsequence

   // Armed start with nothing to move
   sequence s_arm_zero;
      hi_wr && s_q.ctrl1[CTRL1_DMA_EN] && ({pins.data, s_q.count[7:0]} == '0);
   endsequence

   // A written one clears a flag that no event sets
   property p_flag_clear;
      s_flag_wr and (pins.data[0] && !sie_ev.ep_done[0]) |=> !s_q.flags[0];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by written one");

   // A written zero keeps a pending flag
   property p_flag_keep;
      s_flag_wr and (!pins.data[FLAG_USB_RST] && s_q.flags[FLAG_USB_RST]) |=> s_q.flags[FLAG_USB_RST];
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("flag lost on written zero");

   // Status read shows busy above the event flags
   property p_status_read;
      rd_act && (s_q.addr == OFF_INT_FLAGS) |=> data_out == {$past(s_q.busy), $past(s_q.flags)};
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read mismatch");

   // Reserved buffer set bits read as zero
   property p_set_read;
      rd_act && (s_q.addr == OFF_SET_SEL) ##1 rd_act |=> data_out[7:4] == 4'h0;
   endproperty
   a_set_read: assert property (p_set_read) else $error("reserved set bits not zero");

   // Role bit follows the written byte
   property p_role;
      reg_wr && (s_q.addr == OFF_ROLE) |=> ctrl.host_mode == $past(pins.data[ROLE_HOST]);
   endproperty
   a_role: assert property (p_role) else $error("role bit not applied");

   // Polarity bit follows the written byte and stays
   property p_swap;
      reg_wr && (s_q.addr == OFF_ROLE) |=> ctrl.polarity_swap == $past(pins.data[ROLE_SWAP]) [*2];
   endproperty
   a_swap: assert property (p_swap) else $error("polarity bit not applied");

   // Frame low read carries the stored low frame bits
   property p_frame_lo;
      rd_act && (s_q.addr == OFF_FRAME_LO) |=> data_out == {$past(s_q.frame[6:0]), 1'b0};
   endproperty
   a_frame_lo: assert property (p_frame_lo) else $error("frame low read wrong");

   // Frame high read carries the stored high frame bits
   property p_frame_hi;
      rd_act && (s_q.addr == OFF_FRAME_HI) |=> data_out == {$past(s_q.frame[10:7]), 4'h0};
   endproperty
   a_frame_hi: assert property (p_frame_hi) else $error("frame high read wrong");

   // Armed run starts with the full count loaded
   property p_dma_start;
      s_arm |=> s_q.busy && ctrl.dma_start && (s_q.remaining == s_q.count);
   endproperty
   a_dma_start: assert property (p_dma_start) else $error("armed run did not start");

   // High byte write without enable starts nothing
   property p_dma_refuse;
      hi_wr && !s_q.ctrl1[CTRL1_DMA_EN] && !s_q.busy |=> !s_q.busy && !ctrl.dma_start;
   endproperty
   a_dma_refuse: assert property (p_dma_refuse) else $error("run started while disabled");

   // Last byte ends the run and raises done
   property p_dma_done;
      s_last_byte |=> !s_q.busy && s_q.flags[FLAG_DMA_DONE] && !ctrl.endpoint_three_enable;
   endproperty
   a_dma_done: assert property (p_dma_done) else $error("run end not flagged");

   // Request is the masked OR of the flags; busy never counts
   property p_irq;
      interrupt_request_out == |(s_q.flags & s_q.int_en[EVENT_BITS-1:0]);
   endproperty
   a_irq: assert property (p_irq) else $error("request line disagrees with mask");

   // Mask writes leave the flags alone
   property p_mask_only;
      reg_wr && (s_q.addr == OFF_INT_EN) && (setv == '0) |=> s_q.flags == $past(s_q.flags);
   endproperty
   a_mask_only: assert property (p_mask_only) else $error("mask write changed flags");

   // Every start of frame reloads the frame number
   property p_frame_load;
      sie_ev.sof |=> s_q.frame == $past(sie_ev.frame);
   endproperty
   a_frame_load: assert property (p_frame_load) else $error("frame number not captured");

   // A moved byte counts the run down by one
   property p_dma_byte;
      s_mid_byte |=> s_q.busy && (s_q.remaining == $past(s_q.remaining) - COUNT_W'(1));
   endproperty
   a_dma_byte: assert property (p_dma_byte) else $error("byte not counted down");

   // Zero count ends at once, with no start pulse
   property p_zero_count;
      s_arm_zero |=> !s_q.busy && !ctrl.dma_start && s_q.flags[FLAG_DMA_DONE];
   endproperty
   a_zero_count: assert property (p_zero_count) else $error("zero count run misbehaved");

   // Each event sets its flag, even against a clear
   property p_event_set;
      (setv != '0) |=> ((s_q.flags & $past(setv)) == $past(setv));
   endproperty
   a_event_set: assert property (p_event_set) else $error("event did not set its flag");

   // Low count byte takes the written value
   property p_count_wr;
      reg_wr && (s_q.addr == OFF_CNT_LO) |=> s_q.count[7:0] == $past(pins.data);
   endproperty
   a_count_wr: assert property (p_count_wr) else $error("low count not stored");

   // Reserved role bits read as zero
   property p_role_read;
      rd_act && (s_q.addr == OFF_ROLE) |=> data_out[5:0] == 6'h00;
   endproperty
   a_role_read: assert property (p_role_read) else $error("reserved role bits not zero");

   // Direction bit follows the first control register
   property p_dir;
      reg_wr && (s_q.addr == OFF_CTRL1) |=> ctrl.dma_dir == $past(pins.data[CTRL1_DMA_DIR]);
   endproperty
   a_dir: assert property (p_dir) else $error("direction bit not applied");

   // A read strobe drives the data pins at the next edge
   property p_read_drive;
      rd_act |=> data_oe;
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("read data not driven");

endmodule : usb_status_regs

// *** verif/cpu_model.sv ***
`timescale 1ns/10ps
module cpu_model import usb_regs_pkg::*; (
   input wire logic core_clk,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   output cpu_pins_s cpu_pins
);
   logic cs_n = 1'b1; // Chip select, idle high
   logic rd_n = 1'b1; // Read strobe, idle high
   logic wr_n = 1'b1; // Write strobe, idle high
   logic a0 = 1'b0; // Pointer or data select
   logic drv = 1'b0; // Processor owns the data lines
   logic [7:0] wdata = 8'h00; // Byte driven on a write
   logic [7:0] last = 8'h00; // Last level seen on the lines
   logic [7:0] bus; // Resolved data line level
   // Undriven lines toggle each cycle, so nothing stale reads as valid
   // Unknown enable before reset must not smear unknowns onto the idle lines
   assign bus = (data_oe === 1'b1) ? data_out : (drv ? wdata : ~last);
   assign cpu_pins = {cs_n, rd_n, wr_n, a0, bus};
   // Track the line for the floating pattern
   always @(posedge core_clk) begin
      last <= bus;
   end
   // Clocks counted on the falling edge, where pins change
   task automatic wait_clk(input int n);
      repeat (n) @(negedge core_clk);
   endtask : wait_clk
   // Write cycle; data held well past the filter latency
   task automatic bus_write(input logic sel, input logic [7:0] val);
      a0 = sel;
      wdata = val;
      drv = 1'b1;
      wait_clk(6);
      cs_n = 1'b0;
      wr_n = 1'b0;
      wait_clk(7);
      cs_n = 1'b1;
      wr_n = 1'b1;
      wait_clk(5);
      // Released a cycle early, so a following call never flips it in one step
      drv = 1'b0;
      wait_clk(1);
   endtask : bus_write
   // Read cycle; sampled late in the strobe, once settled
   task automatic bus_read(output logic [7:0] val, output logic oe);
      a0 = 1'b1;
      wait_clk(6);
      cs_n = 1'b0;
      rd_n = 1'b0;
      wait_clk(8);
      val = data_out;
      oe = data_oe;
      cs_n = 1'b1;
      rd_n = 1'b1;
      wait_clk(6);
   endtask : bus_read
endmodule : cpu_model

// *** verif/tb.sv ***
`timescale 1ns/10ps
module tb import usb_regs_pkg::*; ();
   logic core_clk = 1'b0; // System clock
   logic sys_rst = 1'b1; // Held high at start
   cpu_pins_s cpu_pins; // Pins from the processor model
   logic [7:0] data_out; // Read data
   logic data_oe; // Read data enable
   sie_events_s sie_ev = '0; // Serial engine stimulus
   ctrl_out_s ctrl; // Control levels out
   logic [15:0] dma_remaining; // Bytes left
   logic interrupt_request_out; // Request line
   int err_total = 0; // Mismatches
   int comparisons = 0; // Checks made
   int cycles = 0; // Hang guard
   int starts = 0; // Start pulses seen
   logic [10:0] fr; // Frame number sent
   logic [7:0] offs [8] = '{OFF_INT_FLAGS, OFF_SET_SEL, OFF_ROLE, OFF_FRAME_LO, OFF_FRAME_HI,
                            OFF_CNT_LO, OFF_CNT_HI, 8'h20}; // Last one unmapped
   always #5 core_clk = ~core_clk;
   usb_status_regs #(.COUNT_W(16)) dut (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .cpu_pins(cpu_pins),
      .data_out(data_out),
      .data_oe(data_oe),
      .sie_ev(sie_ev),
      .ctrl(ctrl),
      .dma_remaining(dma_remaining),
      .interrupt_request_out(interrupt_request_out)
   );
   cpu_model cpu (
      .core_clk(core_clk),
      .data_out(data_out),
      .data_oe(data_oe),
      .cpu_pins(cpu_pins)
   );
   // Count start pulses; a level would count many times
   always @(posedge core_clk) begin
      if (ctrl.dma_start === 1'b1) starts <= starts + 1;
   end
   // Hang guard, far above the expected run of about 2400 cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_total = err_total + 1;
         wrap_up();
      end
   end
   // Compare and report
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Pointer then data
   task automatic reg_write(input logic [7:0] off, input logic [7:0] val);
      cpu.bus_write(1'b0, off);
      cpu.bus_write(1'b1, val);
   endtask : reg_write
   // Pointer then read, drive enable must be up
   task automatic chk_reg(input logic [7:0] off, input logic [7:0] exp);
      logic [7:0] v;
      logic oe;
      cpu.bus_write(1'b0, off);
      cpu.bus_read(v, oe);
      chk(16'(oe), 16'h1);
      chk(16'(v), 16'(exp));
   endtask : chk_reg
   // One-cycle event pulses, then let the flags land
   task automatic pulse(input logic rst, input logic sof, input logic [3:0] epd, input logic byt);
      sie_ev.usb_reset = rst;
      sie_ev.sof = sof;
      sie_ev.ep_done = epd;
      sie_ev.dma_byte = byt;
      @(negedge core_clk);
      sie_ev.usb_reset = 1'b0;
      sie_ev.sof = 1'b0;
      sie_ev.ep_done = 4'h0;
      sie_ev.dma_byte = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask : pulse
   // Counts, verdict, end of run
   task automatic wrap_up();
      $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   // Main sequence
   initial begin
      repeat (5) @(negedge core_clk);
      sys_rst = 1'b0;
      foreach (offs[i]) chk_reg(offs[i], 8'h00);
      chk(16'(interrupt_request_out), 16'h0);
      $display("test reset done");
      // Role and polarity, reserved bits read zero
      reg_write(OFF_ROLE, 8'hff);
      chk_reg(OFF_ROLE, 8'hc0);
      chk(16'({ctrl.host_mode, ctrl.polarity_swap}), 16'h3);
      reg_write(OFF_ROLE, 8'h40);
      chk(16'({ctrl.host_mode, ctrl.polarity_swap}), 16'h1);
      sie_ev.set_sel = 4'ha;
      chk_reg(OFF_SET_SEL, 8'h0a);
      sie_ev.set_sel = 4'h5;
      chk_reg(OFF_SET_SEL, 8'h05);
      $display("test role done");
      // Two frames; the second must replace the first, frame regs only read
      for (int i = 0; i < 2; i++) begin
         fr = (i == 0) ? 11'h5a3 : 11'h2dc;
         sie_ev.frame = fr;
         pulse(1'b1, 1'b1, 4'hf, 1'b0);
         chk_reg(OFF_FRAME_LO, {fr[6:0], 1'b0});
         chk_reg(OFF_FRAME_HI, {fr[10:7], 4'h0});
      end
      chk_reg(OFF_INT_FLAGS, 8'h6f);
      chk(16'(interrupt_request_out), 16'h0);
      reg_write(OFF_INT_EN, 8'h20);
      chk(16'(interrupt_request_out), 16'h1);
      chk_reg(OFF_INT_FLAGS, 8'h6f);
      reg_write(OFF_INT_FLAGS, 8'h00);
      chk_reg(OFF_INT_FLAGS, 8'h6f);
      reg_write(OFF_INT_FLAGS, 8'h20);
      chk_reg(OFF_INT_FLAGS, 8'h4f);
      chk(16'(interrupt_request_out), 16'h0);
      reg_write(OFF_INT_FLAGS, 8'hff);
      reg_write(OFF_INT_EN, 8'h7f);
      chk(16'(interrupt_request_out), 16'h0);
      pulse(1'b0, 1'b0, 4'h4, 1'b0);
      chk(16'(interrupt_request_out), 16'h1);
      chk_reg(OFF_INT_FLAGS, 8'h04);
      reg_write(OFF_INT_FLAGS, 8'h04);
      $display("test events done");
      // Start refused while DMA is disabled; low byte first
      reg_write(OFF_CTRL1, 8'h00);
      reg_write(OFF_CNT_LO, 8'h03);
      reg_write(OFF_CNT_HI, 8'h00);
      chk(16'({starts[0], ctrl.dma_active}), 16'h0);
      chk_reg(OFF_CNT_LO, 8'h03);
      // Enabled run of 0x0102 bytes, device-to-host
      reg_write(OFF_CTRL1, 8'h06);
      reg_write(OFF_CNT_LO, 8'h02);
      reg_write(OFF_CNT_HI, 8'h01);
      chk(16'(starts), 16'h1);
      chk(dma_remaining, 16'h0102);
      chk(16'({ctrl.dma_active, ctrl.dma_dir, ctrl.endpoint_three_enable}), 16'h7);
      chk_reg(OFF_INT_FLAGS, 8'h80);
      chk(16'(interrupt_request_out), 16'h0);
      pulse(1'b0, 1'b0, 4'h0, 1'b1);
      chk(dma_remaining, 16'h0101);
      repeat (257) pulse(1'b0, 1'b0, 4'h0, 1'b1);
      chk(16'({ctrl.dma_active, ctrl.endpoint_three_enable}), 16'h0);
      chk_reg(OFF_INT_FLAGS, 8'h10);
      chk(16'(interrupt_request_out), 16'h1);
      reg_write(OFF_INT_FLAGS, 8'hff);
      // Zero count, host-to-device: done at once
      reg_write(OFF_CTRL1, 8'h02);
      reg_write(OFF_CNT_LO, 8'h00);
      reg_write(OFF_CNT_HI, 8'h00);
      chk(16'({ctrl.dma_active, ctrl.dma_dir}), 16'h0);
      chk_reg(OFF_INT_FLAGS, 8'h10);
      $display("test dma done");
      wrap_up();
   end
endmodule : tb
